// file: hw/stbc_top.v
/*
  Sensorless six-step brushless motor controller with edge-aligned PWM,
  open-loop start-up, back-EMF integration and cycle-by-cycle current limit.
  Assumes a 100 MHz clock, a classic Wishbone master, an external ADC that
  answers conversion requests with a done strobe, and a gate driver.
*/
// The implementer's own choices: the register offsets and the Wishbone slave port.
// What this block does
// - PWM defaults to 20 kHz, period programmable
// - Edge-aligned PWM, no dead band
// - Timer counts up, wraps at period, flags
// - Timer ticks at 25 MHz; period 1251
// - Duty command clamped to ceiling at each wrap
// - Applied duty raised to at least the floor at each closed-loop wrap
// - One winding conversion per PWM cycle
// - Samples are 10-bit codes
// - Integrate from half-bus crossing to threshold
// - Threshold is configurable integer
// - Threshold shifts commutation earlier or later
// - Open loop start then closed loop
// - First start duty is alignment duty
// - Alignment duty ramps to alignment limit
// - Overcurrent reference selectable among three levels
// - Comparator drives PWM fault input
// - Service tick per PWM cycle, conversion event
// - Channels 0 bus, 2 temp, 3-5 windings
// - High side pulses, low side held, third off
// - Back-EMF is phase minus half bus, negated on falling steps
// - Fault turns all gates off after a two-flop sync
`timescale 1ns/1ps
`default_nettype none
`include "stbc_regs.vh"
module stbc_top
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        overcurrent_fault_input_i,
  input  wire        adc_done_i,
  input  wire [9:0]  adc_data_i,
  output reg         adc_start_o,
  output reg  [2:0]  adc_chan_o,
  output reg  [1:0]  comparator_reference_select_o,
  output reg  [2:0]  gate_hi_o,
  output reg  [2:0]  gate_lo_o,
  output reg         pwm_period_evt_o,
  output reg         adc_evt_o
);

  // --------------------------------------------------------------------------
  // States and constants
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_ALIGN = 2'b01;
  localparam [1:0] ST_OPEN  = 2'b10;
  localparam [1:0] ST_CLOSE = 2'b11;
  localparam [2:0] CH_BUS   = 3'h0;
  localparam [2:0] CH_TEMP  = 3'h2;
  localparam [2:0] CH_W0    = 3'h3;

  function [10:0] clamp_duty;
    input [10:0] val;
    input [10:0] lo;
    input [10:0] hi;
    begin
      if (val > hi)
        clamp_duty = hi;
      else if (val < lo)
        clamp_duty = lo;
      else
        clamp_duty = val;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------------
  reg        flt_s1_ff;
  reg        flt_s2_ff;
  reg        done_s1_ff;
  reg        done_s2_ff;
  reg        done_s3_ff;
  reg [9:0]  dat_s1_ff;
  reg [9:0]  dat_s2_ff;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flt_s1_ff  <= 1'b0;
      flt_s2_ff  <= 1'b0;
      done_s1_ff <= 1'b0;
      done_s2_ff <= 1'b0;
      done_s3_ff <= 1'b0;
      dat_s1_ff  <= 10'h000;
      dat_s2_ff  <= 10'h000;
    end
    else
    begin
      flt_s1_ff  <= overcurrent_fault_input_i;
      flt_s2_ff  <= flt_s1_ff;
      done_s1_ff <= adc_done_i;
      done_s2_ff <= done_s1_ff;
      done_s3_ff <= done_s2_ff;
      dat_s1_ff  <= adc_data_i;
      dat_s2_ff  <= dat_s1_ff;
    end
  end

  wire done_rise = done_s2_ff & ~done_s3_ff;

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  reg        run_ff;
  reg [10:0] period_ff;
  reg [10:0] cmd_ff;
  reg [10:0] ceil_ff;
  reg [10:0] floor_ff;
  reg [10:0] align_ff;
  reg [10:0] align_max_ff;
  reg [15:0] thresh_ff;
  reg [15:0] ramp_ff;
  reg [15:0] blank_ff;
  reg [9:0]  bus_v_ff;
  reg [9:0]  temp_ff;
  reg [10:0] duty_ff;
  reg [1:0]  state_ff;
  reg [2:0]  step_ff;
  reg [15:0] ev_cnt_ff;
  reg [10:0] target_ff;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_ff                        <= 1'b0;
      comparator_reference_select_o <= 2'b00;
      period_ff    <= `STBC_PERIOD_RST;
      cmd_ff       <= 11'h000;
      ceil_ff      <= `STBC_CEIL_RST;
      floor_ff     <= `STBC_FLOOR_RST;
      align_ff     <= `STBC_ALIGN_RST;
      align_max_ff <= `STBC_ALIGN_MAX_RST;
      thresh_ff    <= `STBC_THRESH_RST;
      ramp_ff      <= `STBC_RAMP_RST;
      blank_ff     <= `STBC_BLANK_RST;
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_wr)
      begin
        case (wb_adr_i)
          `STBC_ADR_CTRL:
          begin
            run_ff <= wb_dat_i[`STBC_CTRL_RUN];
            // Code 2'b11 is not a level, so it falls back to the lowest one.
            comparator_reference_select_o <=
              (wb_dat_i[`STBC_CTRL_REF_MSB:`STBC_CTRL_REF_LSB] == 2'b11) ? 2'b00 :
              wb_dat_i[`STBC_CTRL_REF_MSB:`STBC_CTRL_REF_LSB];
          end
          `STBC_ADR_PERIOD:    period_ff    <= wb_dat_i[10:0];
          `STBC_ADR_DUTY_CMD:  cmd_ff       <= wb_dat_i[10:0];
          `STBC_ADR_CEIL:      ceil_ff      <= wb_dat_i[10:0];
          `STBC_ADR_FLOOR:     floor_ff     <= wb_dat_i[10:0];
          `STBC_ADR_ALIGN:     align_ff     <= wb_dat_i[10:0];
          `STBC_ADR_ALIGN_MAX: align_max_ff <= wb_dat_i[10:0];
          `STBC_ADR_THRESH:    thresh_ff    <= wb_dat_i[15:0];
          `STBC_ADR_RAMP:
          begin
            ramp_ff  <= wb_dat_i[15:0];
            blank_ff <= wb_dat_i[31:16];
          end
          default:
          begin
          end
        endcase
      end
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `STBC_ADR_CTRL:      wb_dat_o <= {29'h0, comparator_reference_select_o, run_ff};
          `STBC_ADR_PERIOD:    wb_dat_o <= {21'h0, period_ff};
          `STBC_ADR_DUTY_CMD:  wb_dat_o <= {21'h0, cmd_ff};
          `STBC_ADR_CEIL:      wb_dat_o <= {21'h0, ceil_ff};
          `STBC_ADR_FLOOR:     wb_dat_o <= {21'h0, floor_ff};
          `STBC_ADR_ALIGN:     wb_dat_o <= {21'h0, align_ff};
          `STBC_ADR_ALIGN_MAX: wb_dat_o <= {21'h0, align_max_ff};
          `STBC_ADR_THRESH:    wb_dat_o <= {16'h0, thresh_ff};
          `STBC_ADR_RAMP:      wb_dat_o <= {blank_ff, ramp_ff};
          `STBC_ADR_STATUS:    wb_dat_o <= {24'h0, flt_s2_ff, step_ff, 2'b00, state_ff};
          `STBC_ADR_BUS_V:     wb_dat_o <= {22'h0, bus_v_ff};
          `STBC_ADR_TEMP:      wb_dat_o <= {22'h0, temp_ff};
          `STBC_ADR_DUTY_APP:  wb_dat_o <= {21'h0, duty_ff};
          `STBC_ADR_EVENTS:    wb_dat_o <= {16'h0, ev_cnt_ff};
          default:             wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // PWM timer
  // --------------------------------------------------------------------------
  reg [1:0]  div_ff;
  reg [10:0] cnt_ff;
  wire       tmr_en = (div_ff == 2'b11);
  wire       wrap   = tmr_en & (cnt_ff >= period_ff);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_ff           <= 2'b00;
      cnt_ff           <= 11'h000;
      pwm_period_evt_o <= 1'b0;
    end
    else
    begin
      div_ff           <= div_ff + 2'b01;
      pwm_period_evt_o <= wrap;
      if (tmr_en)
        cnt_ff <= wrap ? 11'h000 : cnt_ff + 11'h001;
    end
  end

  // --------------------------------------------------------------------------
  // Start-up sequencer and duty
  // --------------------------------------------------------------------------
  reg  [15:0] tmr_ff;
  wire        int_hit;
  wire        int_armed;
  wire [15:0] int_acc;
  reg         smp_ff;
  wire        commutate_open = (state_ff == ST_OPEN) && wrap && (tmr_ff >= ramp_ff);
  wire        commutate      = commutate_open || ((state_ff == ST_CLOSE) && int_hit);

  always @(posedge clk_i)
  begin
    if (rst_i || !run_ff)
    begin
      state_ff  <= ST_IDLE;
      step_ff   <= 3'h0;
      tmr_ff    <= 16'h0000;
      duty_ff   <= 11'h000;
      target_ff <= 11'h000;
      ev_cnt_ff <= 16'h0000;
    end
    else if (wrap)
    begin
      target_ff <= (cmd_ff > ceil_ff) ? ceil_ff : cmd_ff;
      tmr_ff    <= tmr_ff + 16'h0001;
      // A closed-loop hit that lands on the wrap must still advance the step.
      if (commutate)
      begin
        step_ff   <= (step_ff == 3'h5) ? 3'h0 : step_ff + 3'h1;
        ev_cnt_ff <= ev_cnt_ff + 16'h0001;
      end
      case (state_ff)
        ST_IDLE:
        begin
          state_ff <= ST_ALIGN;
          duty_ff  <= align_ff;
          tmr_ff   <= 16'h0000;
        end
        ST_ALIGN:
          if (tmr_ff >= ramp_ff)
          begin
            tmr_ff <= 16'h0000;
            if (duty_ff >= align_max_ff)
              state_ff <= ST_OPEN;
            else
              duty_ff <= duty_ff + 11'h001;
          end
        ST_OPEN:
          if (commutate)
          begin
            tmr_ff <= 16'h0000;
            if (ev_cnt_ff >= blank_ff)
              state_ff <= ST_CLOSE;
          end
        ST_CLOSE:
          duty_ff <= clamp_duty(target_ff, floor_ff, ceil_ff);
        default:
          state_ff <= ST_IDLE;
      endcase
    end
    else if (commutate && state_ff == ST_CLOSE)
    begin
      step_ff   <= (step_ff == 3'h5) ? 3'h0 : step_ff + 3'h1;
      ev_cnt_ff <= ev_cnt_ff + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Conversion sequence: bus, temperature, then floating winding
  // --------------------------------------------------------------------------
  reg [1:0] seq_ff;
  reg [9:0] phase_ff;
  wire [1:0] float_leg = (step_ff == 3'h0 || step_ff == 3'h3) ? 2'd1 :
                         (step_ff == 3'h1 || step_ff == 3'h4) ? 2'd0 : 2'd2;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seq_ff      <= 2'b00;
      adc_start_o <= 1'b0;
      adc_chan_o  <= CH_BUS;
      adc_evt_o   <= 1'b0;
      bus_v_ff    <= 10'h000;
      temp_ff     <= 10'h000;
      phase_ff    <= 10'h000;
      smp_ff      <= 1'b0;
    end
    else
    begin
      adc_start_o <= 1'b0;
      adc_evt_o   <= done_rise;
      smp_ff      <= 1'b0;
      // Sampling is launched mid on-time so the winding has settled.
      if (tmr_en && cnt_ff == {1'b0, duty_ff[10:1]} && seq_ff == 2'b00)
      begin
        adc_start_o <= 1'b1;
        adc_chan_o  <= CH_BUS;
        seq_ff      <= 2'b01;
      end
      else if (done_rise)
      begin
        case (seq_ff)
          2'b01:
          begin
            bus_v_ff    <= dat_s2_ff;
            adc_chan_o  <= CH_TEMP;
            adc_start_o <= 1'b1;
            seq_ff      <= 2'b10;
          end
          2'b10:
          begin
            temp_ff     <= dat_s2_ff;
            adc_chan_o  <= CH_W0 + {1'b0, float_leg};
            adc_start_o <= 1'b1;
            seq_ff      <= 2'b11;
          end
          2'b11:
          begin
            phase_ff <= dat_s2_ff;
            smp_ff   <= 1'b1;
            seq_ff   <= 2'b00;
          end
          default:
            seq_ff <= 2'b00;
        endcase
      end
    end
  end

  stbc_integrator u_int
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .clr_i      (commutate || state_ff != ST_CLOSE),
    .smp_i      (smp_ff),
    .rising_i   (~step_ff[0]),
    .phase_i    (phase_ff),
    .half_bus_i ({1'b0, bus_v_ff[9:1]}),
    .thresh_i   (thresh_ff),
    .armed_ff   (int_armed),
    .acc_ff     (int_acc),
    .hit_ff     (int_hit)
  );

  // --------------------------------------------------------------------------
  // Gate outputs
  // --------------------------------------------------------------------------
  reg [1:0] hi_leg;
  reg [1:0] lo_leg;
  wire      pwm_on = (cnt_ff < duty_ff) && (state_ff != ST_IDLE);

  always @*
  begin
    case (step_ff)
      3'h0:    begin hi_leg = 2'd0; lo_leg = 2'd2; end
      3'h1:    begin hi_leg = 2'd1; lo_leg = 2'd2; end
      3'h2:    begin hi_leg = 2'd1; lo_leg = 2'd0; end
      3'h3:    begin hi_leg = 2'd2; lo_leg = 2'd0; end
      3'h4:    begin hi_leg = 2'd2; lo_leg = 2'd1; end
      default: begin hi_leg = 2'd0; lo_leg = 2'd1; end
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i || flt_s2_ff)
    begin
      gate_hi_o <= 3'b000;
      gate_lo_o <= 3'b000;
    end
    else
    begin
      gate_hi_o <= pwm_on ? (3'b001 << hi_leg) : 3'b000;
      gate_lo_o <= (state_ff != ST_IDLE) ? (3'b001 << lo_leg) : 3'b000;
    end
  end

endmodule
`default_nettype wire

// file: hw/stbc_regs.vh
/*
  Register offsets, field positions, reset values and timing counts for the
  sensorless trapezoidal motor controller.
  Assumes a 100 MHz system clock and a classic Wishbone slave with 32-bit data.
*/
`ifndef STBC_REGS_VH
`define STBC_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define STBC_ADR_CTRL      8'h00
`define STBC_ADR_PERIOD    8'h04
`define STBC_ADR_DUTY_CMD  8'h08
`define STBC_ADR_CEIL      8'h0C
`define STBC_ADR_FLOOR     8'h10
`define STBC_ADR_ALIGN     8'h14
`define STBC_ADR_ALIGN_MAX 8'h18
`define STBC_ADR_THRESH    8'h1C
`define STBC_ADR_RAMP      8'h20
`define STBC_ADR_STATUS    8'h24
`define STBC_ADR_BUS_V     8'h28
`define STBC_ADR_TEMP      8'h2C
`define STBC_ADR_DUTY_APP  8'h30
`define STBC_ADR_EVENTS    8'h34

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define STBC_CTRL_RUN      0
`define STBC_CTRL_REF_LSB  1
`define STBC_CTRL_REF_MSB  2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define STBC_PERIOD_RST    11'h4E3
`define STBC_CEIL_RST      11'h300
`define STBC_FLOOR_RST     11'h019
`define STBC_ALIGN_RST     11'h00D
`define STBC_ALIGN_MAX_RST 11'h032
`define STBC_THRESH_RST    16'h012C
`define STBC_RAMP_RST      16'h0050
`define STBC_BLANK_RST     16'h0032

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define STBC_SYS_MHZ       100
`define STBC_TMR_MHZ       25
`define STBC_TMR_DIV       (`STBC_SYS_MHZ / `STBC_TMR_MHZ)
`define STBC_ADC_BITS      10
`define STBC_ADC_HALF      10'h200

`endif

// file: hw/stbc_integrator.v
/*
  Back-EMF integrator for the floating phase.
  Assumes samples arrive once per PWM cycle as 10-bit codes with a strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module stbc_integrator
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        clr_i,
  input  wire        smp_i,
  input  wire        rising_i,
  input  wire [9:0]  phase_i,
  input  wire [9:0]  half_bus_i,
  input  wire [15:0] thresh_i,
  output reg         armed_ff,
  output reg  [15:0] acc_ff,
  output reg         hit_ff
);

  wire [10:0] diff_up  = {1'b0, phase_i} - {1'b0, half_bus_i};
  wire [10:0] diff_dn  = {1'b0, half_bus_i} - {1'b0, phase_i};
  wire [10:0] emf      = rising_i ? diff_up : diff_dn;
  wire        crossed  = ~emf[10];
  // A sample back below the centre tap adds nothing, so it cannot wrap the sum.
  wire [9:0]  emf_pos  = crossed ? emf[9:0] : 10'h000;
  wire [16:0] sum      = {1'b0, acc_ff} + {7'h00, emf_pos};

  always @(posedge clk_i)
  begin
    if (rst_i || clr_i)
    begin
      armed_ff <= 1'b0;
      acc_ff   <= 16'h0000;
      hit_ff   <= 1'b0;
    end
    else
    begin
      hit_ff <= 1'b0;
      if (smp_i)
      begin
        if (!armed_ff && crossed)
          armed_ff <= 1'b1;
        if (armed_ff || crossed)
        begin
          acc_ff <= sum[16] ? 16'hFFFF : sum[15:0];
          if (sum >= {1'b0, thresh_i})
            hit_ff <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: dv/stbc_drive_model.sv
/*
  Behavioural gate driver, inverter and ADC front end for stbc_top.
  Assumes one conversion request at a time and leg A on bit 0 and channel 3.
*/
`timescale 1ns/1ps
`default_nettype none
module stbc_drive_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [2:0] chan_i,
  input  wire logic [2:0] hi_i,
  input  wire logic [2:0] lo_i,
  input  wire logic       slow_i,
  output var  logic       done_o,
  output var  logic [9:0] data_o
);
  logic [2:0] hl;
  logic [2:0] lq;
  logic [2:0] k = 3'h0;
  logic [4:0] wt;
  logic [9:0] v;
  wire  [2:0] idx  = chan_i - 3'h3;
  wire  [2:0] fl   = ~(hl | lo_i);
  wire        rise = (fl == {hl[1:0], hl[2]});
  // The floating leg ramps through half bus, upward or downward by step.
  always @(posedge clk_i)
  begin
    if (hi_i != 3'h0)
      hl <= hi_i;
    lq <= lo_i;
    if ((hi_i != 3'h0 && hi_i != hl) || lo_i != lq)
      k <= 3'h0;
    else if (start_i && chan_i > 3'h2 && fl[idx] && k != 3'h7)
      k <= k + 3'h1;
    if (rst_i)
    begin
      wt <= 5'h0;
      done_o <= 1'b0;
    end
    else if (start_i)
    begin
      wt <= slow_i ? 5'h18 : 5'h6;
      done_o <= 1'b0;
      data_o <= ~data_o;
      v <= (chan_i == 3'h0) ? 10'h300 : (chan_i == 3'h2) ? 10'h123 :
           hl[idx] ? 10'h300 : lq[idx] ? 10'h000 :
           rise ? 10'h140 + {k, 6'h00} : 10'h1C0 - {k, 6'h00};
    end
    else if (wt != 5'h0)
    begin
      wt <= wt - 5'h1;
      done_o <= (wt < 5'h6) && (wt > 5'h1);
      data_o <= (wt < 5'h6 && wt > 5'h1) ? v : ~v;
    end
  end
endmodule
`default_nettype wire

// file: dv/stbc_props.sv
/*
  Pin-level assertions for stbc_top.
  Assumes the bind below; sees only the controller's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module stbc_props
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       overcurrent_fault_input_i,
  input wire logic       adc_done_i,
  input wire logic       adc_start_o,
  input wire logic [2:0] adc_chan_o,
  input wire logic [1:0] comparator_reference_select_o,
  input wire logic [2:0] gate_hi_o,
  input wire logic [2:0] gate_lo_o,
  input wire logic       pwm_period_evt_o,
  input wire logic       adc_evt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_leg_no_overlap: assert property ((gate_hi_o & gate_lo_o) == 3'h0)
    else $error("both switches of a leg on");
  a_one_leg_each: assert property ($countones(gate_hi_o) < 2 && $countones(gate_lo_o) < 2)
    else $error("more than one leg per side");
  a_fault_off: assert property (overcurrent_fault_input_i [*3] |=> gate_hi_o == 3'h0)
    else $error("high side on during overcurrent");
  a_done_event: assert property ($rose(adc_done_i) |-> ##[1:5] adc_evt_o)
    else $error("conversion event missing");
  a_wrap_pulse: assert property (pwm_period_evt_o |=> !pwm_period_evt_o [*3])
    else $error("period event too long");
  a_chan_legal: assert property (adc_start_o |-> adc_chan_o inside {0, 2, 3, 4, 5})
    else $error("bad conversion channel");
  a_start_pulse: assert property (adc_start_o |=> !adc_start_o)
    else $error("conversion start too long");
  a_ref_legal: assert property (comparator_reference_select_o != 2'h3)
    else $error("reserved reference level");
  cover property (pwm_period_evt_o);
  cover property (adc_evt_o);
  cover property ($changed(gate_lo_o) && gate_lo_o != 3'h0);
  cover property (overcurrent_fault_input_i && gate_lo_o != 3'h0);
endmodule
bind stbc_top stbc_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .overcurrent_fault_input_i, .adc_done_i, .adc_start_o, .adc_chan_o,
  .comparator_reference_select_o, .gate_hi_o, .gate_lo_o, .pwm_period_evt_o, .adc_evt_o);
`default_nettype wire

// file: dv/test_stbc_top.sv
/*
  Self-checking bench for stbc_top.
  Assumes the drive model answers conversions; the bench is Wishbone master.
*/
`timescale 1ns/1ps
`default_nettype none
module test_stbc_top;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow, dprev;
  logic        overcurrent_fault_input_i, adc_done_i, adc_start_o;
  logic        pwm_period_evt_o, adc_evt_o;
  logic [1:0]  comparator_reference_select_o;
  logic [2:0]  adc_chan_o, gate_hi_o, gate_lo_o, hl, lq;
  logic [3:0]  wb_sel_i;
  logic [5:0]  chseen;
  logic [7:0]  wb_adr_i;
  logic [9:0]  adc_data_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          mismatches, tests_run, cyc_n, ncom, ndone, nevt, nwind, npev, n, h;
  stbc_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .overcurrent_fault_input_i, .adc_done_i,
    .adc_data_i, .adc_start_o, .adc_chan_o, .comparator_reference_select_o,
    .gate_hi_o, .gate_lo_o, .pwm_period_evt_o, .adc_evt_o);
  stbc_drive_model u_drv (.clk_i, .rst_i, .start_i(adc_start_o), .chan_i(adc_chan_o),
    .hi_i(gate_hi_o), .lo_i(gate_lo_o), .slow_i(slow), .done_o(adc_done_i),
    .data_o(adc_data_i));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // --------------------------------------------------------------------------
  // Monitors and shared tasks
  // --------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    cyc_n++;
    dprev <= adc_done_i;
    if (adc_done_i && !dprev) ndone++;
    if (adc_evt_o) nevt++;
    if (pwm_period_evt_o) npev++;
    if (adc_start_o) chseen[adc_chan_o] <= 1'b1;
    if (adc_start_o && adc_chan_o > 3'h2) nwind++;
    if ((gate_hi_o != 3'h0 && gate_hi_o != hl) || gate_lo_o != lq) ncom++;
    if (gate_hi_o != 3'h0) hl <= gate_hi_o;
    lq <= gate_lo_o;
    if (cyc_n == 100000)
    begin
      mismatches++;
      test_done();
    end
  end
  task test_done;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(rd, e);
  endtask
  // Counts clocks of one PWM period and the clocks with a high side on.
  task span;
    @(posedge clk_i);
    while (pwm_period_evt_o !== 1'b1) @(posedge clk_i);
    n = 0;
    h = 0;
    do
    begin
      @(posedge clk_i);
      n++;
      if (gate_hi_o != 3'h0) h++;
    end while (pwm_period_evt_o !== 1'b1);
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task t_reset_vals;
    logic [7:0]  a [9];
    logic [31:0] e [9];
    a = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h3C};
    e = '{32'h0, 32'h4E3, 32'h300, 32'h19, 32'hD, 32'h32, 32'h12C, 32'h320050, 32'h0};
    for (int i = 0; i < 9; i++)
      rdc(a[i], e[i]);
  endtask
  task t_refused;
    wb(1'b1, 8'h0C, 32'h123, 4'h0);
    rdc(8'h0C, 32'h300);
    wb(1'b1, 8'h3C, 32'h5A, 4'hF);
    rdc(8'h3C, 32'h0);
  endtask
  task t_refsel;
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, 8'h00, 32'(i * 2), 4'hF);
      repeat (2) @(posedge clk_i);
      chk({30'h0, comparator_reference_select_o}, (i == 3) ? 32'h0 : 32'(i));
    end
  endtask
  task t_run;
    logic [7:0]  a [7];
    logic [31:0] d [7];
    a = '{8'h04, 8'h10, 8'h0C, 8'h18, 8'h20, 8'h08, 8'h00};
    d = '{32'h63, 32'h5, 32'h3C, 32'h10, 32'h20004, 32'h7FF, 32'h1};
    for (int i = 0; i < 7; i++)
      wb(1'b1, a[i], d[i], 4'hF);
    span();
    chk(n, 32'd400);
    wb(1'b0, 8'h30, 32'h0, 4'hF);
    chk({31'h0, rd >= 32'hD && rd <= 32'h10}, 32'h1);
    repeat (30) span();
    rdc(8'h30, 32'h3C);
    span();
    chk({31'h0, h >= 236 && h <= 244}, 32'h1);
    wb(1'b1, 8'h08, 32'h2, 4'hF);
    repeat (2) span();
    rdc(8'h30, 32'h5);
  endtask
  task t_threshold;
    int c1, c2, n0, e0;
    wb(1'b0, 8'h34, 32'h0, 4'hF);
    e0 = int'(rd);
    n0 = ncom;
    repeat (25) span();
    c1 = ncom - n0;
    wb(1'b1, 8'h1C, 32'h40, 4'hF);
    slow <= 1'b1;
    c2 = ncom;
    repeat (25) span();
    c2 = ncom - c2;
    chk({31'h0, c1 > 0}, 32'h1);
    chk({31'h0, c2 > c1}, 32'h1);
    wb(1'b0, 8'h34, 32'h0, 4'hF);
    e0 = int'(rd) - e0 - (ncom - n0);
    chk({31'h0, e0 >= -1 && e0 <= 1}, 32'h1);
  endtask
  task t_fault;
    overcurrent_fault_input_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk({29'h0, gate_hi_o}, 32'h0);
    wb(1'b0, 8'h24, 32'h0, 4'hF);
    chk({31'h0, rd[7]}, 32'h1);
    overcurrent_fault_input_i <= 1'b0;
    repeat (2) span();
    chk({31'h0, h >= 16 && h <= 24}, 32'h1);
  endtask
  task t_adc;
    rdc(8'h28, 32'h300);
    rdc(8'h2C, 32'h123);
    chk({26'h0, chseen}, 32'h3D);
    chk({31'h0, ndone - nevt <= 1}, 32'h1);
    chk({31'h0, nwind >= npev - 2}, 32'h1);
  endtask
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, overcurrent_fault_input_i, slow} = 6'h20;
    {wb_adr_i, wb_sel_i, wb_dat_i, chseen, dprev, hl, lq} = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_vals();
    t_refused();
    t_refsel();
    t_run();
    t_threshold();
    t_fault();
    t_adc();
    test_done();
  end
endmodule
`default_nettype wire
